/* sc_regs.svh */
// Contract
// - a write is chip select low together with write strobe low.
// - a read is chip select and output enable low, write strobe held high.
// - read data valid 55 ns after address; reads at least 55 ns apart.
// - write address stable, low pulses at least 40 ns, writes 55 ns apart.
// - write data valid at least 25 ns before write end, held to end.
// - controller never drives data while the device may still drive it.
`ifndef SC_REGS_SVH
`define SC_REGS_SVH

`define SC_CLK_NS     50
`define SC_T_AA_NS    55
`define SC_T_RC_NS    55
`define SC_T_PWE_NS   40
`define SC_T_SD_NS    25
`define SC_T_WC_NS    55
// least times round up to whole cycles
`define SC_CEIL(ns)   (((ns) + `SC_CLK_NS - 1) / `SC_CLK_NS)
`define SC_RD_CYC     `SC_CEIL(`SC_T_AA_NS)
`define SC_PWE_CYC    `SC_CEIL(`SC_T_PWE_NS)
`define SC_SD_CYC     `SC_CEIL(`SC_T_SD_NS)
`define SC_WR_CYC     ((`SC_PWE_CYC > `SC_SD_CYC) ? `SC_PWE_CYC : `SC_SD_CYC)
`define SC_SYNC_CYC   2
`define SC_IDLE_LVL   1'b1

`endif

/* sc_pkg.sv */
`default_nettype none
package sc_pkg;
  typedef enum logic [2:0] {
    SC_IDLE,
    SC_W_SETUP,
    SC_W_PULSE,
    SC_W_HOLD,
    SC_R_ACC
  } sc_state_type;
  typedef logic [15:0] sc_word_type;
  typedef logic [15:0] sc_addr_type;
  typedef logic [1:0]  sc_lane_type;
endpackage : sc_pkg
`default_nettype wire

/* sc_tmr_if.sv */
`default_nettype none
interface sc_tmr_if #(parameter int W = 4);
  logic         load;
  logic [W-1:0] load_val;
  logic         done;
  modport ctl (output load, output load_val, input done);
  modport tmr (input load, input load_val, output done);
endinterface : sc_tmr_if
`default_nettype wire

/* sc_timer.sv */
`default_nettype none
// done stays low in the load cycle and for n cycles after a load of n
module sc_timer #(
  parameter int W = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  sc_tmr_if.tmr     t
);
  import sc_pkg::*;
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  assign cnt_nxt = t.load ? t.load_val : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
  assign t.done  = (cnt_r == '0) && !t.load;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : sc_timer
`default_nettype wire

/* sc_sram_ctl.sv */
`default_nettype none
`include "sc_regs.svh"
module sc_sram_ctl #(
  parameter int TW = 4
) (
  input  wire logic            clk_i,
  input  wire logic            rst_b_i,
  // user side
  input  wire logic            req_i,
  input  wire logic            wr_i,
  input  wire sc_pkg::sc_addr_type addr_i,
  input  wire sc_pkg::sc_word_type wdata_i,
  input  wire sc_pkg::sc_lane_type lane_en_i,
  output logic                 ack_o,
  output logic                 busy_o,
  output sc_pkg::sc_word_type  rdata_o,
  // memory pins
  output logic                 chip_select_n_o,
  output logic                 write_strobe_n_o,
  output logic                 output_enable_n_o,
  output logic                 upper_lane_enable_n_o,
  output logic                 lower_lane_enable_n_o,
  output sc_pkg::sc_addr_type  mem_addr_o,
  output sc_pkg::sc_word_type  mem_dq_o,
  output logic                 mem_dq_oe_o,
  input  wire sc_pkg::sc_word_type mem_dq_i
);
  import sc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check: the timer must hold the longest access count
  if (TW < 2 || (1 << TW) <= (`SC_RD_CYC + `SC_SYNC_CYC) || (1 << TW) <= `SC_WR_CYC) begin : g_tw_check
    $error("sc_sram_ctl: TW too small for access counts");
  end

  localparam logic [TW-1:0] RD_LOAD = TW'(`SC_RD_CYC + `SC_SYNC_CYC);
  localparam logic [TW-1:0] WR_LOAD = TW'(`SC_WR_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // lane enables are active high at the user port and active low on the pins
  function automatic sc_lane_type lane_to_pins(input sc_lane_type en);
    lane_to_pins = ~en;
  endfunction : lane_to_pins

  // one down-counter times the write pulse and the read access
  sc_tmr_if #(.W(TW)) tmr ();
  sc_timer #(.W(TW)) u_timer (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .t       (tmr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state and registered pins
  sc_state_type state_r, state_nxt;
  logic         cs_n_r, cs_n_nxt;
  logic         we_n_r, we_n_nxt;
  logic         oe_n_r, oe_n_nxt;
  sc_lane_type  lane_n_r, lane_n_nxt;
  sc_addr_type  addr_r, addr_nxt;
  sc_word_type  dq_r, dq_nxt;
  logic         dq_oe_r, dq_oe_nxt;
  sc_word_type  rdata_r, rdata_nxt;
  logic         ack_r, ack_nxt;
  logic         busy_r;
  sc_word_type  sync1_r, sync2_r;
  logic         tload;
  logic [TW-1:0] tval;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire accept    = (state_r == SC_IDLE) && req_i;
  wire no_lanes  = (lane_en_i == 2'b00);
  wire start_wr  = accept && !no_lanes && wr_i;
  wire start_rd  = accept && !no_lanes && !wr_i;
  wire timer_end = tmr.done;
  wire [15:0] lane_mask = {{8{!lane_n_r[1]}}, {8{!lane_n_r[0]}}};

  // the timer is loaded only on a state change
  assign tmr.load     = tload;
  assign tmr.load_val = tval;

  always_comb begin
    state_nxt  = state_r;
    cs_n_nxt   = cs_n_r;
    we_n_nxt   = we_n_r;
    oe_n_nxt   = oe_n_r;
    lane_n_nxt = lane_n_r;
    addr_nxt   = addr_r;
    dq_nxt     = dq_r;
    dq_oe_nxt  = dq_oe_r;
    rdata_nxt  = rdata_r;
    ack_nxt    = 1'b0;
    tload      = 1'b0;
    tval       = '0;
    case (state_r)
      SC_IDLE: begin
        // all strobes high keeps the memory in standby
        cs_n_nxt   = `SC_IDLE_LVL;
        we_n_nxt   = `SC_IDLE_LVL;
        oe_n_nxt   = `SC_IDLE_LVL;
        lane_n_nxt = {2{`SC_IDLE_LVL}};
        dq_oe_nxt  = 1'b0;
        if (accept && no_lanes) begin
          ack_nxt = 1'b1; // empty request never strobes the memory
        end
        if (start_wr) begin
          // address stable for the whole write, write strobe still high
          // whole sixteen-bit word address, one location per address
          addr_nxt   = addr_i;
          lane_n_nxt = lane_to_pins(lane_en_i); // per-lane write selection
          dq_nxt     = wdata_i;
          cs_n_nxt   = 1'b0;
          oe_n_nxt   = 1'b1; // device outputs stay off, so driving is safe
          dq_oe_nxt  = 1'b1; // data set up well ahead of write end
          state_nxt  = SC_W_SETUP;
        end
        if (start_rd) begin
          addr_nxt   = addr_i; // address only moves on accept, idle otherwise
          lane_n_nxt = lane_to_pins(lane_en_i);
          // lanes open onto a bus the controller has already left
          dq_oe_nxt  = 1'b0;
          cs_n_nxt   = 1'b0;
          oe_n_nxt   = 1'b0;
          we_n_nxt   = 1'b1;
          tload      = 1'b1;
          tval       = RD_LOAD; // access time plus input synchroniser
          state_nxt  = SC_R_ACC;
        end
      end
      SC_W_SETUP: begin
        we_n_nxt  = 1'b0; // select and strobe low together open the write
        tload     = 1'b1;
        tval      = WR_LOAD; // strobe pulse width and data setup
        state_nxt = SC_W_PULSE;
      end
      SC_W_PULSE: begin
        if (timer_end) begin
          // select and strobe rise together; data held one more cycle
          we_n_nxt   = 1'b1;
          cs_n_nxt   = 1'b1;
          lane_n_nxt = 2'b11;
          state_nxt  = SC_W_HOLD;
        end
      end
      SC_W_HOLD: begin
        // data lines released a cycle after the strobe rose
        dq_oe_nxt = 1'b0;
        ack_nxt   = 1'b1;
        state_nxt = SC_IDLE; // setup, pulse and hold exceed the write cycle time
      end
      SC_R_ACC: begin
        if (timer_end) begin
          // keep only enabled lanes of the synchronised pins
          rdata_nxt  = sync2_r & lane_mask;
          cs_n_nxt   = 1'b1;
          oe_n_nxt   = 1'b1;
          lane_n_nxt = 2'b11;
          ack_nxt    = 1'b1;
          state_nxt  = SC_IDLE;
        end
      end
      default: begin
        state_nxt = SC_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r  <= SC_IDLE;
      cs_n_r   <= 1'b1;
      we_n_r   <= 1'b1;
      oe_n_r   <= 1'b1;
      lane_n_r <= 2'b11;
      addr_r   <= '0;
      dq_r     <= '0;
      dq_oe_r  <= 1'b0;
      rdata_r  <= '0;
      ack_r    <= 1'b0;
      busy_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cs_n_r   <= cs_n_nxt;
      we_n_r   <= we_n_nxt;
      oe_n_r   <= oe_n_nxt;
      lane_n_r <= lane_n_nxt;
      addr_r   <= addr_nxt;
      dq_r     <= dq_nxt;
      dq_oe_r  <= dq_oe_nxt;
      rdata_r  <= rdata_nxt;
      ack_r    <= ack_nxt;
      busy_r   <= (state_nxt != SC_IDLE);
    end
  end

  // two-stage synchroniser on the data pins
  // only the second stage feeds logic
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= mem_dq_i;
      sync2_r <= sync1_r;
    end
  end

  assign ack_o                 = ack_r;
  assign busy_o                = busy_r;
  assign rdata_o               = rdata_r;
  assign chip_select_n_o       = cs_n_r;
  assign write_strobe_n_o      = we_n_r;
  assign output_enable_n_o     = oe_n_r;
  assign upper_lane_enable_n_o = lane_n_r[1];
  assign lower_lane_enable_n_o = lane_n_r[0];
  assign mem_addr_o            = addr_r;
  assign mem_dq_o              = dq_r;
  assign mem_dq_oe_o           = dq_oe_r;
endmodule : sc_sram_ctl
`default_nettype wire

/* sc_sram_chk.sv */
`default_nettype none
module sc_sram_chk (
  input wire logic                clk_i,
  input wire logic                rst_b_i,
  input wire logic                req_i,
  input wire logic                wr_i,
  input wire sc_pkg::sc_lane_type lane_en_i,
  input wire logic                busy_o,
  input wire logic                ack_o,
  input wire logic                chip_select_n_o,
  input wire logic                write_strobe_n_o,
  input wire logic                output_enable_n_o,
  input wire logic                upper_lane_enable_n_o,
  input wire logic                lower_lane_enable_n_o,
  input wire sc_pkg::sc_addr_type mem_addr_o,
  input wire logic                mem_dq_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import sc_pkg::*;
  wire take = req_i && !busy_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence wr_seq;
    !chip_select_n_o && output_enable_n_o && mem_dq_oe_o ##1 (!write_strobe_n_o) [*2]
    ##1 write_strobe_n_o && chip_select_n_o ##1 ack_o && !mem_dq_oe_o;
  endsequence
  sequence rd_seq;
    (!chip_select_n_o && !output_enable_n_o && write_strobe_n_o) [*5] ##1 ack_o && chip_select_n_o;
  endsequence
  wr_walk_a: assert property (take && wr_i && |lane_en_i |=> wr_seq)
    else $error("write cycle wrong");
  rd_walk_a: assert property (take && !wr_i && |lane_en_i |=> rd_seq)
    else $error("read cycle wrong");
  lane_pins_a: assert property (take && |lane_en_i |=>
    {upper_lane_enable_n_o, lower_lane_enable_n_o} == ~$past(lane_en_i)) else $error("lane pins wrong");
  empty_ack_a: assert property (take && lane_en_i == 2'h0 |=> ack_o && chip_select_n_o)
    else $error("empty request touched memory");
  no_fight_a: assert property (mem_dq_oe_o |-> output_enable_n_o)
    else $error("data driven while outputs on");
  strobe_sel_a: assert property (!write_strobe_n_o |-> !chip_select_n_o &&
    !(upper_lane_enable_n_o && lower_lane_enable_n_o) && $past(mem_dq_oe_o) ##1 mem_dq_oe_o)
    else $error("write strobe without select or data");
  addr_hold_a: assert property (!chip_select_n_o && !$past(chip_select_n_o) |-> $stable(mem_addr_o))
    else $error("address moved in access");
  sel_width_a: assert property ($fell(chip_select_n_o) |=> !chip_select_n_o)
    else $error("select pulse too short");
endmodule : sc_sram_chk
bind sc_sram_ctl sc_sram_chk i_sc_sram_chk (
  .clk_i                 (clk_i),
  .rst_b_i               (rst_b_i),
  .req_i                 (req_i),
  .wr_i                  (wr_i),
  .lane_en_i             (lane_en_i),
  .busy_o                (busy_o),
  .ack_o                 (ack_o),
  .chip_select_n_o       (chip_select_n_o),
  .write_strobe_n_o      (write_strobe_n_o),
  .output_enable_n_o     (output_enable_n_o),
  .upper_lane_enable_n_o (upper_lane_enable_n_o),
  .lower_lane_enable_n_o (lower_lane_enable_n_o),
  .mem_addr_o            (mem_addr_o),
  .mem_dq_oe_o           (mem_dq_oe_o)
);
`default_nettype wire

/* sc_sram_mdl.sv */
`default_nettype none
module sc_sram_mdl (
  input  wire logic                cs_n_i,
  input  wire logic                we_n_i,
  input  wire logic                oe_n_i,
  input  wire logic                up_n_i,
  input  wire logic                lo_n_i,
  input  wire sc_pkg::sc_addr_type addr_i,
  input  wire sc_pkg::sc_word_type din_i,
  output sc_pkg::sc_word_type      dout_o,
  output sc_pkg::sc_lane_type      drv_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import sc_pkg::*;
  sc_word_type mem [0:65535];
  wire wr_on = !cs_n_i && !we_n_i && !(up_n_i && lo_n_i);
  wire rd_on = !cs_n_i && we_n_i && !oe_n_i;
  always @(wr_on, addr_i, din_i, up_n_i, lo_n_i) begin
    if (wr_on && !lo_n_i) mem[addr_i][7:0] = din_i[7:0];
    if (wr_on && !up_n_i) mem[addr_i][15:8] = din_i[15:8];
  end
  // lanes turn on late; a released lane shows the inverse of the word
  assign #20 drv_o = rd_on ? ~{up_n_i, lo_n_i} : 2'h0;
  // outputs move only when the address, the strobes or the word move
  assign #20 dout_o = {drv_o[1] ? mem[addr_i][15:8] : ~mem[addr_i][15:8],
                       drv_o[0] ? mem[addr_i][7:0] : ~mem[addr_i][7:0]};
endmodule : sc_sram_mdl
`default_nettype wire

/* tb_top.sv */
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sc_pkg::*;
  logic        clk_i = 0, rst_b_i = 0, req_i = 0, wr_i = 0;
  sc_addr_type addr_i = '0, maddr;
  sc_word_type wdata_i = '0, rdata_o, dq_o, dq_dev, dq_i;
  sc_lane_type lane_en_i = '0, drv;
  logic        ack_o, busy_o, cs_n, we_n, oe_n, up_n, lo_n, dq_oe;
  int          bad_count = 0, checked = 0;
  assign dq_i = dq_oe ? dq_o : dq_dev;
  sc_sram_ctl i_sc_sram_ctl (.clk_i, .rst_b_i, .req_i, .wr_i, .addr_i, .wdata_i, .lane_en_i, .ack_o, .busy_o,
    .rdata_o, .chip_select_n_o(cs_n), .write_strobe_n_o(we_n), .output_enable_n_o(oe_n),
    .upper_lane_enable_n_o(up_n), .lower_lane_enable_n_o(lo_n), .mem_addr_o(maddr), .mem_dq_o(dq_o),
    .mem_dq_oe_o(dq_oe), .mem_dq_i(dq_i));
  sc_sram_mdl i_sc_sram_mdl (.cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n), .up_n_i(up_n), .lo_n_i(lo_n),
    .addr_i(maddr), .din_i(dq_i), .dout_o(dq_dev), .drv_o(drv));
  initial forever #25 clk_i = ~clk_i;
  always @(negedge clk_i) `CHK("bus fight", 1'b0, dq_oe & |drv)
  task automatic xfer(input logic w, input sc_addr_type a, input sc_word_type d, input sc_lane_type l,
                      input int lat);
    int n;
    n = 0;
    req_i <= 1'b1;
    wr_i <= w;
    addr_i <= a;
    wdata_i <= d;
    lane_en_i <= l;
    @(posedge clk_i);
    req_i <= 1'b0;
    do begin
      @(negedge clk_i);
      n++;
      if (n == 1) `CHK("busy in access", l != 2'h0, busy_o)
    end while (ack_o !== 1'b1 && n < 20);
    `CHK("ack delay", lat, n)
    `CHK("busy at ack", 1'b0, busy_o)
    if (!w) `CHK("read data", d, rdata_o)
    @(posedge clk_i);
  endtask : xfer
  task t_lanes;
    xfer(1'b1, 16'h0000, 16'h1234, 2'h3, 5);
    xfer(1'b1, 16'h0000, 16'habcd, 2'h2, 5);
    xfer(1'b0, 16'h0000, 16'hab34, 2'h3, 6);
    xfer(1'b0, 16'h0000, 16'h0034, 2'h1, 6);
    xfer(1'b0, 16'h0000, 16'hab00, 2'h2, 6);
  endtask : t_lanes
  task t_empty;
    xfer(1'b1, 16'h0000, 16'hffff, 2'h0, 1);
    xfer(1'b0, 16'h0000, 16'hab34, 2'h3, 6);
  endtask : t_empty
  task t_top;
    xfer(1'b1, 16'hffff, 16'h5aa5, 2'h3, 5);
    xfer(1'b0, 16'hffff, 16'h5aa5, 2'h3, 6);
    xfer(1'b1, 16'hffff, 16'h00c3, 2'h1, 5);
    xfer(1'b0, 16'hffff, 16'h5ac3, 2'h3, 6);
    xfer(1'b0, 16'h0000, 16'hab34, 2'h3, 6);
  endtask : t_top
  task give_verdict;
    $display("mismatches %0d of %0d checks", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_lanes;
    t_empty;
    t_top;
    give_verdict;
  end
  initial begin
    #20000;
    bad_count++;
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
